// File: hw/mvtf_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - wide variant: 32-bit up/down counter and prescaler
// - full variants: 16-bit up/down counter and prescaler
// - mid-range variants: 16-bit up-only counter
// - mid-range: two or one channel, one complementary
// - mid-range channels capture, compare, pwm, one-pulse
// - full variants: four independent multi-purpose channels
// - full variants: own dma requests, quadrature encoder
// - mid-range variants: independent dma requests
// - advanced: three complementary pairs with dead time
// - advanced: four general-purpose channels too
// - advanced pwm: edge/center aligned, 0-100 %
// - debug halt freezes counter, disables pwm outputs
// - general variants freeze counter in debug
// - link output syncs or chains other timers
// - basic: no channels, time base triggers dac
// - advanced may count from pll tick
// - timer events trigger adc regular/injected start
module mvtf_timer
    import mvtf_pkg::*;
#(
    parameter mvtf_variant_e VARIANT = MVTF_ADVANCED,
    localparam int CW = mvtf_cnt_width(VARIANT)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic cnt_enable,
    input wire logic [1:0] count_mode,
    input wire logic one_pulse,
    input wire logic [CW-1:0] prescale,
    input wire logic [CW-1:0] reload,
    input wire logic clk_src_pll,
    input wire logic pll_tick,
    input wire logic encoder_en,
    input wire logic enc_a_pin,
    input wire logic enc_b_pin,
    input wire logic [1:0] slave_mode,
    input wire logic link_trig_in,
    input wire logic dbg_halt,
    input wire logic dbg_freeze_en,
    input wire logic dbg_out_off,
    input wire logic main_out_en,
    input wire logic [MVTF_DT_W-1:0] dead_time,
    input wire logic [MVTF_MAX_CH-1:0][2:0] ch_mode,
    input wire logic [MVTF_MAX_CH-1:0][CW-1:0] ch_cmp,
    input wire logic [MVTF_MAX_CH-1:0] ch_in_pin,
    output logic [CW-1:0] cnt_value,
    output logic cnt_down,
    output logic update_evt,
    output logic dma_req,
    output logic link_trig_out,
    output logic adc_reg_trig,
    output logic adc_inj_trig,
    output logic dac_trig,
    output logic [MVTF_MAX_CH-1:0] ch_out,
    output logic [MVTF_MAX_CH-1:0] ch_out_n,
    output logic [MVTF_MAX_CH-1:0][CW-1:0] ch_capt,
    output logic [MVTF_MAX_CH-1:0] capt_evt,
    output logic [MVTF_MAX_CH-1:0] cmp_evt
);

    localparam int NCH = mvtf_ch_count(VARIANT);
    localparam int INJ_CH = (NCH > 0) ? NCH - 1 : 0;
    localparam logic [MVTF_MAX_CH-1:0] COMP_MASK = mvtf_comp_mask(VARIANT);
    localparam bit UPDOWN = mvtf_has_updown(VARIANT);
    localparam bit ENCODER = mvtf_has_encoder(VARIANT);
    localparam bit IS_ADV = VARIANT == MVTF_ADVANCED;
    localparam bit IS_BASIC = VARIANT == MVTF_BASIC;
    localparam int NPIN = MVTF_MAX_CH + 2;
    localparam int ENC_A = MVTF_MAX_CH;
    localparam int ENC_B = MVTF_MAX_CH + 1;

    typedef enum {MVTF_IDLE, MVTF_RUN, MVTF_DONE} mvtf_run_e;

    mvtf_run_e run_q, run_d;
    logic [CW-1:0] cnt_q, psc_q;
    logic dn_q, moved_q, update_q, dma_q, link_q, adc_reg_q, adc_inj_q, dac_q;
    logic [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [MVTF_MAX_CH-1:0] capt_evt_w, cmp_evt_w;

    // pins pass two flops; the third stage only keeps history for edge detection
    wire [NPIN-1:0] pin_raw = {enc_b_pin, enc_a_pin, ch_in_pin};
    wire [NPIN-1:0] pin_rise = pin_s2_q & ~pin_s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else if (clk_en) begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // inter-timer link: the input resets, gates or starts this counter
    wire slave_rst = (slave_mode == MVTF_SLV_RESET) && link_trig_in;
    wire gate_ok = (slave_mode != MVTF_SLV_GATE) || link_trig_in;
    wire start_ok = cnt_enable && ((slave_mode != MVTF_SLV_START) || link_trig_in);
    wire running = run_q == MVTF_RUN;

    // debug halt stops counting only when software opted in
    wire freeze = dbg_halt && dbg_freeze_en;
    wire out_off = !main_out_en || (freeze && dbg_out_off);

    // the pll tick is an enable in this clock domain, one pulse per pll count
    wire src_tick = (IS_ADV && clk_src_pll) ? pll_tick : 1'b1;
    wire count_en = running && gate_ok && !freeze && src_tick;
    wire psc_wrap = psc_q >= prescale;
    wire tick = count_en && psc_wrap;
    // prescaler is as wide as the counter: 32 bits on the wide variant
    wire [CW-1:0] psc_d = slave_rst ? '0 :
                          !count_en ? psc_q :
                          psc_wrap ? '0 : CW'(psc_q + 1'h1);

    // quadrature decode counts every edge of either phase
    wire enc_active = ENCODER && encoder_en;
    wire enc_a_chg = pin_s2_q[ENC_A] ^ pin_s3_q[ENC_A];
    wire enc_b_chg = pin_s2_q[ENC_B] ^ pin_s3_q[ENC_B];
    wire enc_down = pin_s3_q[ENC_A] ^ pin_s2_q[ENC_B];
    wire enc_step = (enc_a_chg ^ enc_b_chg) && running && gate_ok && !freeze;

    // variants without down counting ignore the mode selection
    wire [1:0] mode_eff = UPDOWN ? count_mode : MVTF_CNT_UP;
    wire center = !enc_active && (mode_eff == MVTF_CNT_CENTER);
    wire step = enc_active ? enc_step : tick;
    wire going_down = enc_active ? enc_down : (mode_eff == MVTF_CNT_DOWN) || (center && dn_q);
    wire at_top = cnt_q == reload;
    wire at_bot = cnt_q == '0;

    wire [CW-1:0] cnt_up_nx = !at_top ? CW'(cnt_q + 1'h1) : center ? CW'(cnt_q - 1'h1) : '0;
    wire [CW-1:0] cnt_dn_nx = !at_bot ? CW'(cnt_q - 1'h1) : center ? CW'(cnt_q + 1'h1) : reload;
    wire [CW-1:0] cnt_d = slave_rst ? '0 : !step ? cnt_q : going_down ? cnt_dn_nx : cnt_up_nx;
    wire update = step && !slave_rst && (going_down ? at_bot : at_top);

    // center mode turns round at both ends; the encoder sets direction from its phases; otherwise direction follows the mode
    wire center_dn = step ? (going_down ? !at_bot : at_top) : dn_q;
    wire enc_dn = step ? enc_down : dn_q;
    wire dn_d = slave_rst ? 1'b0 :
                enc_active ? enc_dn :
                center ? center_dn : (mode_eff == MVTF_CNT_DOWN);

    // dma requests come from every event of this timer alone; the link request from its update only
    wire dma_d = update || (|capt_evt_w) || (|cmp_evt_w);
    wire adc_reg_d = !IS_BASIC && update;
    wire adc_inj_d = !IS_BASIC && cmp_evt_w[INJ_CH];
    wire dac_d = IS_BASIC && update;

    always_comb begin
        run_d = run_q;
        case (run_q)
            MVTF_IDLE: begin
                if (start_ok) begin
                    run_d = MVTF_RUN;
                end
            end
            MVTF_RUN: begin
                if (!cnt_enable) begin
                    run_d = MVTF_IDLE;
                end else if (update && one_pulse) begin
                    run_d = MVTF_DONE;
                end
            end
            MVTF_DONE: begin
                // one-pulse needs the enable dropped before it can run again
                if (!cnt_enable) begin
                    run_d = MVTF_IDLE;
                end
            end
            default: begin
                run_d = MVTF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= MVTF_IDLE;
            cnt_q <= '0;
            psc_q <= '0;
            dn_q <= 1'b0;
            moved_q <= 1'b0;
        end else if (clk_en) begin
            run_q <= run_d;
            cnt_q <= cnt_d;
            psc_q <= psc_d;
            dn_q <= dn_d;
            moved_q <= step || slave_rst;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            update_q <= 1'b0;
            dma_q <= 1'b0;
            link_q <= 1'b0;
            adc_reg_q <= 1'b0;
            adc_inj_q <= 1'b0;
            dac_q <= 1'b0;
        end else if (clk_en) begin
            update_q <= update;
            dma_q <= dma_d;
            link_q <= update;
            adc_reg_q <= adc_reg_d;
            adc_inj_q <= adc_inj_d;
            dac_q <= dac_d;
        end
    end

    for (genvar i = 0; i < MVTF_MAX_CH; i++) begin : g_ch
        if (i < NCH) begin : g_on
            // channel count per variant; basic has none
            mvtf_channel #(
                .CW(CW),
                .HAS_COMP(COMP_MASK[i])
            ) u_ch (
                .clk(clk),
                .rst(rst),
                .clk_en(clk_en),
                .cnt(cnt_q),
                .cnt_moved(moved_q),
                .mode(ch_mode[i]),
                .cmp(ch_cmp[i]),
                .capt_edge(pin_rise[i]),
                .out_off(out_off),
                .dead_time(dead_time),
                .oc(ch_out[i]),
                .ocn(ch_out_n[i]),
                .capt(ch_capt[i]),
                .capt_evt(capt_evt_w[i]),
                .cmp_evt(cmp_evt_w[i])
            );
        end else begin : g_off
            assign ch_out[i] = 1'b0;
            assign ch_out_n[i] = 1'b0;
            assign ch_capt[i] = '0;
            assign capt_evt_w[i] = 1'b0;
            assign cmp_evt_w[i] = 1'b0;
        end
    end

    assign cnt_value = cnt_q;
    assign cnt_down = dn_q;
    assign update_evt = update_q;
    assign dma_req = dma_q;
    assign link_trig_out = link_q;
    assign adc_reg_trig = adc_reg_q;
    assign adc_inj_trig = adc_inj_q;
    assign dac_trig = dac_q;
    assign capt_evt = capt_evt_w;
    assign cmp_evt = cmp_evt_w;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    up_wrap_a: assert property ((clk_en && step && !going_down && at_top && !center && !slave_rst) |=>
        (cnt_q == '0 && update_q)) else $error("up counter did not wrap with update");
    down_reload_a: assert property ((clk_en && step && going_down && at_bot && !center && !slave_rst) |=>
        (cnt_q == $past(reload) && update_q)) else $error("down counter did not reload");
    up_only_a: assert property ((!UPDOWN && clk_en && step && !slave_rst) |=>
        (cnt_q == CW'($past(cnt_q) + 1'h1) || cnt_q == '0)) else $error("mid-range counter moved down");
    prescale_hold_a: assert property ((clk_en && !enc_active && !psc_wrap && !slave_rst) |=>
        $stable(cnt_q)) else $error("counter moved before prescaler wrapped");
    center_turn_a: assert property ((clk_en && center && step && !going_down && at_top && !slave_rst) |=>
        (dn_q && update_q)) else $error("center mode did not turn at the top");
    debug_freeze_a: assert property ((clk_en && freeze && !slave_rst) |=> $stable(cnt_q))
        else $error("counter moved during debug halt");
    debug_out_off_a: assert property ((clk_en && freeze && dbg_out_off) |=>
        (ch_out == '0 && ch_out_n == '0)) else $error("outputs driven during debug halt");
    encoder_up_a: assert property ((clk_en && enc_active && step && !enc_down && !at_top && !slave_rst) |=>
        cnt_q == CW'($past(cnt_q) + 1'h1)) else $error("encoder edge did not count up");
    link_reset_a: assert property ((clk_en && slave_rst) |=> (cnt_q == '0 && psc_q == '0))
        else $error("link reset did not clear the counter");
    dma_request_a: assert property ((clk_en && update) |=> (dma_q && link_q))
        else $error("update gave no dma or link request");
    adc_trigger_a: assert property ((clk_en && update) |=> (adc_reg_q == !IS_BASIC && dac_q == IS_BASIC))
        else $error("update routed to the wrong converter trigger");
    basic_quiet_a: assert property (IS_BASIC |-> (capt_evt_w == '0 && ch_out == '0))
        else $error("basic timer shows channel activity");
    pll_source_a: assert property ((IS_ADV && clk_src_pll && !pll_tick) |-> !tick)
        else $error("advanced timer counted without a pll tick");
    one_pulse_a: assert property ((clk_en && running && update && one_pulse && cnt_enable) |=>
        (run_q == MVTF_DONE) ##1 (run_q == MVTF_DONE || !$past(cnt_enable))) else $error("one-pulse did not stop");

    cover_wrap_c: cover property (clk_en && update && !going_down);
    cover_center_c: cover property (clk_en && center && update && dn_q);
    cover_encoder_c: cover property (clk_en && enc_active && step && enc_down);
    cover_one_pulse_c: cover property (run_q == MVTF_DONE);

endmodule : mvtf_timer

// File: hw/mvtf_pkg.sv
package mvtf_pkg;

    typedef enum {
        MVTF_ADVANCED,
        MVTF_WIDE,
        MVTF_FULL,
        MVTF_MID_TWO,
        MVTF_MID_ONE,
        MVTF_BASIC
    } mvtf_variant_e;

    localparam int MVTF_MAX_CH = 4;
    localparam int MVTF_MID_TWO_CH = 2;
    localparam int MVTF_MID_ONE_CH = 1;
    localparam int MVTF_WIDE_W = 32;
    localparam int MVTF_STD_W = 16;
    localparam int MVTF_DT_W = 8;
    localparam int MVTF_SYSCLK_MHZ = 100;
    localparam int MVTF_PLL_MAX_MHZ = 144;

    localparam logic [1:0] MVTF_CNT_UP = 2'h0;
    localparam logic [1:0] MVTF_CNT_DOWN = 2'h1;
    localparam logic [1:0] MVTF_CNT_CENTER = 2'h2;

    localparam logic [1:0] MVTF_SLV_NONE = 2'h0;
    localparam logic [1:0] MVTF_SLV_RESET = 2'h1;
    localparam logic [1:0] MVTF_SLV_GATE = 2'h2;
    localparam logic [1:0] MVTF_SLV_START = 2'h3;

    localparam logic [2:0] MVTF_CH_OFF = 3'h0;
    localparam logic [2:0] MVTF_CH_CAPTURE = 3'h1;
    localparam logic [2:0] MVTF_CH_TOGGLE = 3'h2;
    localparam logic [2:0] MVTF_CH_ACTIVE = 3'h3;
    localparam logic [2:0] MVTF_CH_INACTIVE = 3'h4;
    localparam logic [2:0] MVTF_CH_PWM1 = 3'h5;
    localparam logic [2:0] MVTF_CH_PWM2 = 3'h6;

    // complementary outputs: three phases on the advanced timer, one pair on mid-range
    localparam logic [MVTF_MAX_CH-1:0] MVTF_COMP_ADV = 4'h7;
    localparam logic [MVTF_MAX_CH-1:0] MVTF_COMP_MID = 4'h1;

    function automatic int mvtf_cnt_width(mvtf_variant_e v);
        return (v == MVTF_WIDE) ? MVTF_WIDE_W : MVTF_STD_W;
    endfunction : mvtf_cnt_width

    function automatic int mvtf_ch_count(mvtf_variant_e v);
        case (v)
            MVTF_MID_TWO: return MVTF_MID_TWO_CH;
            MVTF_MID_ONE: return MVTF_MID_ONE_CH;
            MVTF_BASIC: return 0;
            default: return MVTF_MAX_CH;
        endcase
    endfunction : mvtf_ch_count

    function automatic logic [MVTF_MAX_CH-1:0] mvtf_comp_mask(mvtf_variant_e v);
        case (v)
            MVTF_ADVANCED: return MVTF_COMP_ADV;
            MVTF_MID_TWO, MVTF_MID_ONE: return MVTF_COMP_MID;
            default: return '0;
        endcase
    endfunction : mvtf_comp_mask

    function automatic bit mvtf_has_updown(mvtf_variant_e v);
        return (v == MVTF_ADVANCED) || (v == MVTF_WIDE) || (v == MVTF_FULL);
    endfunction : mvtf_has_updown

    function automatic bit mvtf_has_encoder(mvtf_variant_e v);
        return (v == MVTF_WIDE) || (v == MVTF_FULL);
    endfunction : mvtf_has_encoder

endpackage : mvtf_pkg

// File: hw/mvtf_channel.sv
`timescale 1ns/1ps
module mvtf_channel
    import mvtf_pkg::*;
#(
    parameter int CW = MVTF_STD_W,
    parameter bit HAS_COMP = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [CW-1:0] cnt,
    input wire logic cnt_moved,
    input wire logic [2:0] mode,
    input wire logic [CW-1:0] cmp,
    input wire logic capt_edge,
    input wire logic out_off,
    input wire logic [MVTF_DT_W-1:0] dead_time,
    output logic oc,
    output logic ocn,
    output logic [CW-1:0] capt,
    output logic capt_evt,
    output logic cmp_evt
);

    logic ref_q, oc_q, ocn_q, capt_evt_q, cmp_evt_q;
    logic [CW-1:0] capt_q;
    logic [MVTF_DT_W-1:0] dt_q;

    wire match = cnt_moved && (cnt == cmp);
    wire pwm_lt = cnt < cmp;
    wire drives = (mode != MVTF_CH_OFF) && (mode != MVTF_CH_CAPTURE);
    // pwm1 with cmp of zero gives 0 %, cmp above reload gives 100 %
    wire ref_d = (mode == MVTF_CH_PWM1) ? pwm_lt :
                 (mode == MVTF_CH_PWM2) ? !pwm_lt :
                 (mode == MVTF_CH_TOGGLE && match) ? !ref_q :
                 (mode == MVTF_CH_ACTIVE && match) ? 1'b1 :
                 (mode == MVTF_CH_INACTIVE && match) ? 1'b0 :
                 drives ? ref_q : 1'b0;
    wire ref_edge = ref_d != ref_q;
    // every reference edge restarts the gap so both switches are off first
    wire [MVTF_DT_W-1:0] dt_d = ref_edge ? dead_time : (dt_q != '0) ? dt_q - 1'h1 : dt_q;
    wire dt_idle = dt_q == '0;
    wire oc_d = drives && !out_off && ref_q && dt_idle;
    wire ocn_d = HAS_COMP && drives && !out_off && !ref_q && dt_idle;
    wire capt_evt_d = (mode == MVTF_CH_CAPTURE) && capt_edge;
    wire cmp_evt_d = match && drives;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_q <= 1'b0;
            dt_q <= '0;
            oc_q <= 1'b0;
            ocn_q <= 1'b0;
            capt_q <= '0;
            capt_evt_q <= 1'b0;
            cmp_evt_q <= 1'b0;
        end else if (clk_en) begin
            ref_q <= ref_d;
            dt_q <= dt_d;
            oc_q <= oc_d;
            ocn_q <= ocn_d;
            capt_q <= capt_evt_d ? cnt : capt_q;
            capt_evt_q <= capt_evt_d;
            cmp_evt_q <= cmp_evt_d;
        end
    end

    assign oc = oc_q;
    assign ocn = ocn_q;
    assign capt = capt_q;
    assign capt_evt = capt_evt_q;
    assign cmp_evt = cmp_evt_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    pair_no_overlap_a: assert property (!(oc_q && ocn_q)) else $error("both outputs of a pair high");
    dead_gap_a: assert property ((clk_en && ref_edge && dead_time != '0) ##1 clk_en |=> (!oc_q && !ocn_q))
        else $error("dead time gap not kept");
    capture_latch_a: assert property ((clk_en && mode == MVTF_CH_CAPTURE && capt_edge) |=>
        (capt_evt_q && capt_q == $past(cnt))) else $error("capture did not latch the counter");
    cover_capture_c: cover property (capt_evt_q);

endmodule : mvtf_channel

// File: tb/mvtf_pin_model.sv
`timescale 1ns/1ps
// far side of the advanced timer: capture pins that the bench can pulse, and the
// gate drivers, every leg watched for shoot-through and the first phase for dead gaps
module mvtf_pin_model
    import mvtf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [MVTF_MAX_CH-1:0] fire,
    input wire logic [MVTF_MAX_CH-1:0] ch_out,
    input wire logic [MVTF_MAX_CH-1:0] ch_out_n,
    output logic [MVTF_MAX_CH-1:0] ch_in_pin,
    output logic enc_a_pin,
    output logic enc_b_pin,
    output logic overlap,
    output logic [7:0] min_gap
);
    logic [MVTF_MAX_CH-1:0] fire_q;
    logic [MVTF_MAX_CH-1:0] mask_q;
    logic [2:0] hold_q;
    logic [7:0] gap_q;
    wire logic [MVTF_MAX_CH-1:0] fire_rise = fire & ~fire_q;
    wire logic both_low = !ch_out[0] && !ch_out_n[0];

    // nonblocking updates on the rising edge: the bench's falling-edge stimulus cannot race them
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fire_q <= '0;
            mask_q <= '0;
            hold_q <= 3'h0;
            ch_in_pin <= '0;
            enc_a_pin <= 1'b0;
            enc_b_pin <= 1'b0;
            overlap <= 1'b0;
            // saturated until a leg is first driven, so the idle after reset is not taken as a gap
            gap_q <= 8'hff;
            min_gap <= 8'hff;
        end else begin
            fire_q <= fire;
            if (|fire_rise) begin
                mask_q <= fire_rise;
                hold_q <= 3'h4;
            end else if (hold_q != 3'h0) begin
                hold_q <= hold_q - 3'h1;
            end
            ch_in_pin <= (hold_q != 3'h0) ? mask_q : '0;
            // both switches of one leg on at once would short the supply
            if (|(ch_out & ch_out_n)) begin
                overlap <= 1'b1;
            end
            if (both_low) begin
                gap_q <= (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
            end else begin
                if (gap_q != 8'h00 && gap_q < min_gap) begin
                    min_gap <= gap_q;
                end
                gap_q <= 8'h00;
            end
        end
    end
endmodule : mvtf_pin_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import mvtf_pkg::*;
;
    localparam int TW = MVTF_STD_W;
    typedef struct {logic [1:0] mode; int pre; int rel; int per;} mvtf_tb_row_s;
    mvtf_tb_row_s rows[5] = '{'{MVTF_CNT_UP, 0, 4, 5}, '{MVTF_CNT_UP, 2, 3, 12}, '{MVTF_CNT_DOWN, 0, 5, 6},
                             '{MVTF_CNT_CENTER, 0, 4, 4}, '{MVTF_CNT_CENTER, 1, 4, 8}};
    logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, cnt_enable = 1'b0, one_pulse = 1'b0, encoder_en = 1'b0;
    logic clk_src_pll = 1'b0, pll_tick = 1'b0, pll_run = 1'b0, link_trig_in = 1'b0, main_out_en = 1'b1;
    logic dbg_halt = 1'b0, dbg_freeze_en = 1'b0, dbg_out_off = 1'b0;
    logic [1:0] count_mode = MVTF_CNT_UP, slave_mode = MVTF_SLV_NONE;
    logic [TW-1:0] prescale = '0, reload = '0, v;
    logic [7:0] dead_time = 8'h00, min_gap;
    logic [MVTF_MAX_CH-1:0][2:0] ch_mode = '0;
    logic [MVTF_MAX_CH-1:0][TW-1:0] ch_cmp = '0, ch_capt;
    logic [MVTF_MAX_CH-1:0] fire = '0, ch_in_pin, ch_out, ch_out_n, capt_evt, cmp_evt;
    logic [TW-1:0] cnt_value;
    logic cnt_down, update_evt, dma_req, link_trig_out, adc_reg_trig, enc_a_pin, enc_b_pin, overlap;
    logic adc_inj_trig, dac_trig;
    int n_fail = 0, checks = 0, n, k;

    always #5 clk = ~clk;
    always @(negedge clk) pll_tick <= pll_run & ~pll_tick;

    mvtf_timer #(.VARIANT(MVTF_ADVANCED)) dut (.clk(clk), .rst(rst), .clk_en(clk_en), .cnt_enable(cnt_enable),
        .count_mode(count_mode), .one_pulse(one_pulse), .prescale(prescale), .reload(reload),
        .clk_src_pll(clk_src_pll), .pll_tick(pll_tick), .encoder_en(encoder_en), .enc_a_pin(enc_a_pin),
        .enc_b_pin(enc_b_pin), .slave_mode(slave_mode), .link_trig_in(link_trig_in), .dbg_halt(dbg_halt),
        .dbg_freeze_en(dbg_freeze_en), .dbg_out_off(dbg_out_off), .main_out_en(main_out_en),
        .dead_time(dead_time), .ch_mode(ch_mode), .ch_cmp(ch_cmp), .ch_in_pin(ch_in_pin), .cnt_value(cnt_value),
        .cnt_down(cnt_down), .update_evt(update_evt), .dma_req(dma_req), .link_trig_out(link_trig_out),
        .adc_reg_trig(adc_reg_trig), .adc_inj_trig(adc_inj_trig), .dac_trig(dac_trig),
        .ch_out(ch_out), .ch_out_n(ch_out_n), .ch_capt(ch_capt), .capt_evt(capt_evt), .cmp_evt(cmp_evt));

    mvtf_pin_model pins (.clk(clk), .rst(rst), .fire(fire), .ch_out(ch_out), .ch_out_n(ch_out_n),
        .ch_in_pin(ch_in_pin), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin), .overlap(overlap),
        .min_gap(min_gap));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic close_out();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        cnt_enable = 1'b0;
        one_pulse = 1'b0;
        clk_src_pll = 1'b0;
        pll_run = 1'b0;
        count_mode = MVTF_CNT_UP;
        prescale = '0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
    endtask : do_reset

    // cycles from here to the next update pulse, bounded so a dead counter cannot hang the run
    task automatic wait_upd(output int cyc);
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while (update_evt !== 1'b1 && cyc < 5000);
    endtask : wait_upd

    initial begin
        #200_000;
        n_fail++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 5; i++) begin
            do_reset();
            count_mode = rows[i].mode;
            prescale = TW'(rows[i].pre);
            reload = TW'(rows[i].rel);
            cnt_enable = 1'b1;
            wait_upd(n);
            wait_upd(n);
            chk_val(32'(n), 32'(rows[i].per));
            chk_bit(adc_reg_trig, 1'b1);
            chk_bit(link_trig_out, 1'b1);
            chk_bit(dma_req, 1'b1);
            chk_bit(dac_trig, 1'b0);
            if (rows[i].mode == MVTF_CNT_UP) chk_val(32'(cnt_value), 32'h0000_0000);
            if (rows[i].mode == MVTF_CNT_DOWN) chk_bit(cnt_down, 1'b1);
        end
        // duty at both ends of the range: never on, always on
        do_reset();
        reload = 16'h0007;
        ch_mode[0] = MVTF_CH_PWM1;
        foreach (rows[i]) if (i < 2) begin
            ch_cmp[0] = (i == 0) ? 16'h0000 : 16'h0009;
            cnt_enable = 1'b1;
            repeat (20) @(negedge clk);
            k = 0;
            repeat (8) begin
                @(negedge clk);
                k += (ch_out[0] === 1'b1);
            end
            chk_val(32'(k), (i == 0) ? 32'h0000_0000 : 32'h0000_0008);
        end
        // half duty with dead time: no overlap, gaps at least the programmed length
        do_reset();
        reload = 16'h000f;
        ch_cmp[0] = 16'h0008;
        dead_time = 8'h04;
        // the last channel toggles at a count of five and feeds the injected converter trigger
        ch_mode[3] = MVTF_CH_TOGGLE;
        ch_cmp[3] = 16'h0005;
        cnt_enable = 1'b1;
        k = 0;
        n = 0;
        repeat (80) begin
            @(negedge clk);
            k += (adc_inj_trig === 1'b1);
            n += (cmp_evt[3] === 1'b1);
        end
        chk_val(32'(k), 32'h0000_0005);
        chk_val(32'(n), 32'h0000_0005);
        chk_bit(overlap, 1'b0);
        chk_bit(min_gap >= 8'h04 && min_gap < 8'hff, 1'b1);
        ch_cmp[0] = 16'h0010;
        repeat (30) @(negedge clk);
        chk_bit(ch_out[0], 1'b1);
        dbg_halt = 1'b1;
        dbg_freeze_en = 1'b1;
        dbg_out_off = 1'b1;
        repeat (2) @(negedge clk);
        v = cnt_value;
        repeat (10) @(negedge clk);
        chk_val(32'(cnt_value), 32'(v));
        chk_val(32'(ch_out), 32'h0000_0000);
        chk_val(32'(ch_out_n), 32'h0000_0000);
        dbg_halt = 1'b0;
        // gated counter holds still, so the captured value is known exactly
        ch_mode[1] = MVTF_CH_CAPTURE;
        slave_mode = MVTF_SLV_GATE;
        link_trig_in = 1'b1;
        repeat (5) @(negedge clk);
        link_trig_in = 1'b0;
        repeat (3) @(negedge clk);
        v = cnt_value;
        fire = 4'h2;
        @(negedge clk);
        fire = 4'h0;
        k = 0;
        while (capt_evt[1] !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk_bit(capt_evt[1], 1'b1);
        chk_val(32'(ch_capt[1]), 32'(v));
        chk_val(32'(cnt_value), 32'(v));
        slave_mode = MVTF_SLV_RESET;
        link_trig_in = 1'b1;
        repeat (3) @(negedge clk);
        chk_val(32'(cnt_value), 32'h0000_0000);
        link_trig_in = 1'b0;
        slave_mode = MVTF_SLV_NONE;
        // one pulse: a single update, then the counter parks at zero
        do_reset();
        one_pulse = 1'b1;
        reload = 16'h0003;
        cnt_enable = 1'b1;
        wait_upd(n);
        k = 0;
        repeat (20) begin
            @(negedge clk);
            k += (update_evt === 1'b1);
        end
        chk_val(32'(k), 32'h0000_0000);
        chk_val(32'(cnt_value), 32'h0000_0000);
        // pll tick on every other cycle halves the count rate
        do_reset();
        clk_src_pll = 1'b1;
        pll_run = 1'b1;
        reload = 16'h0004;
        cnt_enable = 1'b1;
        wait_upd(n);
        wait_upd(n);
        chk_val(32'(n), 32'h0000_000a);
        close_out();
    end
endmodule : testbench
